/* lke_core.sv */
// legacy keyboard and mouse emulation: port trap, gate tracking, irq forwarding
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module lke_core #(
  parameter logic [7:0] GATE_BIT = 8'h02 // bit of the 60h byte that carries the gate level
) (
  input  wire logic                       clk_i,        // controller clock, 100 MHz
  input  wire logic                       nrst_i,       // synchronous reset, active low
  input  wire logic [lke_pkg::ADDR_W-1:0] reg_addr_i,   // register byte address
  input  wire logic [31:0]                reg_wdata_i,  // register write data
  input  wire logic                       reg_wr_i,     // register write strobe
  input  wire logic                       reg_rd_i,     // register read strobe
  output logic      [31:0]                reg_rdata_o,  // read data, cycle after strobe
  input  wire lke_pkg::lke_io_t           io_i,         // trapped host i/o access
  output logic      [7:0]                 io_rdata_o,   // data returned for port read
  output logic                            io_trap_o,    // access was claimed by emulation
  input  wire logic                       kbc_irq1_i,   // keyboard controller irq1 pin
  input  wire logic                       kbc_irq12_i,  // keyboard controller irq12 pin
  output logic                            irq1_o,       // irq1 toward the system
  output logic                            irq12_o,      // irq12 toward the system
  output logic                            emu_irq_o,    // emulation interrupt
  output logic                            gate_mismatch_o // 60h gate byte differs from state
);
  // a zero mask would make every gate byte look low
  if (GATE_BIT == 8'h00) begin : g_gate_bit_check
    $error("lke_core: GATE_BIT must not be zero");
  end

  logic [1:0] kbc_level;
  logic [1:0] kbc_rise;

  lke_edge #(
    .WIDTH (2)
  ) u_edge (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i ({kbc_irq12_i, kbc_irq1_i}),
    .level_o (kbc_level),
    .rise_o  (kbc_rise)
  );

  // control state (bits 8:0, bit 1 is not stored)
  logic       emu_on;
  logic       char_pending;
  logic       legacy_irq_enable;
  logic       external_irq_enable;
  logic       gate_sequence_flag;
  logic       irq1_active;
  logic       irq12_active;
  logic       address_gate_state;
  logic [7:0] input_byte;
  logic [7:0] output_byte;
  logic [7:0] status;
  logic [31:0] rdata;
  logic       mismatch;

  logic       next_emu_on;
  logic       next_char_pending;
  logic       next_legacy_irq_enable;
  logic       next_external_irq_enable;
  logic       next_gate_sequence_flag;
  logic       next_irq1_active;
  logic       next_irq12_active;
  logic       next_address_gate_state;
  logic [7:0] next_input_byte;
  logic [7:0] next_output_byte;
  logic [7:0] next_status;
  logic [31:0] next_rdata;
  logic       next_mismatch;

  logic wr_ctrl;
  logic wr_in;
  logic wr_out;
  logic wr_stat;
  logic io_wr_data;
  logic io_wr_cmd;
  logic io_rd_data;
  logic emu_cond;
  logic [31:0] ctrl_view;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == lke_pkg::OFF_CTRL);
  assign wr_in   = reg_wr_i && (reg_addr_i == lke_pkg::OFF_IN);
  assign wr_out  = reg_wr_i && (reg_addr_i == lke_pkg::OFF_OUT);
  assign wr_stat = reg_wr_i && (reg_addr_i == lke_pkg::OFF_STAT);

  // trapping only while emulation is on; otherwise the real controller answers
  assign io_wr_data = emu_on && io_i.wr && (io_i.port == lke_pkg::PORT_DATA);
  assign io_wr_cmd  = emu_on && io_i.wr && (io_i.port == lke_pkg::PORT_CMD);
  assign io_rd_data = emu_on && io_i.rd && (io_i.port == lke_pkg::PORT_DATA);
  assign io_trap_o  = emu_on && (io_i.wr || io_i.rd) &&
                      ((io_i.port == lke_pkg::PORT_DATA) ||
                       (io_i.port == lke_pkg::PORT_CMD));

  // live decode, never stored, so it reads back as bit 1
  always_comb begin
    emu_cond = 1'b0;
    if (emu_on && status[lke_pkg::S_IN_FULL]) emu_cond = 1'b1;
    if (char_pending && !status[lke_pkg::S_OUT_FULL]) emu_cond = 1'b1;
    if (external_irq_enable && (kbc_level[0] || kbc_level[1])) emu_cond = 1'b1;
  end

  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[lke_pkg::C_EMU_ON]    = emu_on;
    ctrl_view[lke_pkg::C_EMU_IRQ]   = emu_cond;
    ctrl_view[lke_pkg::C_CHAR_PND]  = char_pending;
    ctrl_view[lke_pkg::C_IRQ_EN]    = legacy_irq_enable;
    ctrl_view[lke_pkg::C_EXT_EN]    = external_irq_enable;
    ctrl_view[lke_pkg::C_GATE_SEQ]  = gate_sequence_flag;
    ctrl_view[lke_pkg::C_IRQ1_ACT]  = irq1_active;
    ctrl_view[lke_pkg::C_IRQ12_ACT] = irq12_active;
    ctrl_view[lke_pkg::C_GATE_ST]   = address_gate_state;
  end

  always_comb begin
    next_emu_on              = emu_on;
    next_char_pending        = char_pending;
    next_legacy_irq_enable   = legacy_irq_enable;
    next_external_irq_enable = external_irq_enable;
    next_gate_sequence_flag  = gate_sequence_flag;
    next_irq1_active         = irq1_active;
    next_irq12_active        = irq12_active;
    next_address_gate_state  = address_gate_state;
    next_input_byte          = input_byte;
    next_output_byte         = output_byte;
    next_status              = status;
    next_mismatch            = mismatch;
    next_rdata               = 32'h0000_0000;

    // software writes first, so that hardware events below win over clears
    if (wr_ctrl) begin
      next_emu_on              = reg_wdata_i[lke_pkg::C_EMU_ON];
      next_char_pending        = reg_wdata_i[lke_pkg::C_CHAR_PND];
      next_legacy_irq_enable   = reg_wdata_i[lke_pkg::C_IRQ_EN];
      next_external_irq_enable = reg_wdata_i[lke_pkg::C_EXT_EN];
      next_address_gate_state  = reg_wdata_i[lke_pkg::C_GATE_ST];
      if (reg_wdata_i[lke_pkg::C_IRQ1_ACT])  next_irq1_active  = 1'b0;
      if (reg_wdata_i[lke_pkg::C_IRQ12_ACT]) next_irq12_active = 1'b0;
    end
    if (wr_in) next_input_byte = reg_wdata_i[7:0];
    if (wr_out) next_output_byte = reg_wdata_i[7:0];
    if (wr_stat) next_status = reg_wdata_i[7:0];

    if (kbc_rise[0]) next_irq1_active  = 1'b1;
    if (kbc_rise[1]) next_irq12_active = 1'b1;

    if (io_wr_cmd) begin
      next_input_byte = io_i.data;
      next_gate_sequence_flag = (io_i.data == lke_pkg::CMD_GATE);
      next_status[lke_pkg::S_CMD_DATA] = 1'b1;
      // the d1h itself opens the sequence and is absorbed like a matching data byte
      if (!(gate_sequence_flag || (io_i.data == lke_pkg::CMD_GATE)))
        next_status[lke_pkg::S_IN_FULL] = 1'b1;
      else if (!gate_sequence_flag)
        next_status[lke_pkg::S_IN_FULL] = 1'b0;
    end
    if (io_wr_data) begin
      next_input_byte = io_i.data;
      next_status[lke_pkg::S_CMD_DATA] = 1'b0;
      if (gate_sequence_flag) begin
        // matching gate level needs no software; a mismatch is handed over
        next_mismatch = (|(io_i.data & GATE_BIT)) != address_gate_state;
        if (next_mismatch) next_status[lke_pkg::S_IN_FULL] = 1'b1;
      end else begin
        next_status[lke_pkg::S_IN_FULL] = 1'b1;
      end
    end
    if (io_rd_data) next_status[lke_pkg::S_OUT_FULL] = 1'b0;

    if (reg_rd_i) begin
      case (reg_addr_i)
        lke_pkg::OFF_CTRL: next_rdata = ctrl_view;
        lke_pkg::OFF_IN:   next_rdata = {24'h00_0000, input_byte};
        lke_pkg::OFF_OUT:  next_rdata = {24'h00_0000, output_byte};
        lke_pkg::OFF_STAT: next_rdata = {24'h00_0000, status};
        default:           next_rdata = 32'h0000_0000;
      endcase
    end

    if (!nrst_i) begin
      next_emu_on              = lke_pkg::CTRL_RST[lke_pkg::C_EMU_ON];
      next_char_pending        = lke_pkg::CTRL_RST[lke_pkg::C_CHAR_PND];
      next_legacy_irq_enable   = lke_pkg::CTRL_RST[lke_pkg::C_IRQ_EN];
      next_external_irq_enable = lke_pkg::CTRL_RST[lke_pkg::C_EXT_EN];
      next_gate_sequence_flag  = lke_pkg::CTRL_RST[lke_pkg::C_GATE_SEQ];
      next_irq1_active         = lke_pkg::CTRL_RST[lke_pkg::C_IRQ1_ACT];
      next_irq12_active        = lke_pkg::CTRL_RST[lke_pkg::C_IRQ12_ACT];
      next_address_gate_state  = lke_pkg::CTRL_RST[lke_pkg::C_GATE_ST];
      next_input_byte          = lke_pkg::BYTE_RST;
      next_output_byte         = lke_pkg::BYTE_RST;
      next_status              = lke_pkg::STAT_RST;
      next_mismatch            = 1'b0;
      next_rdata               = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    emu_on              <= next_emu_on;
    char_pending        <= next_char_pending;
    legacy_irq_enable   <= next_legacy_irq_enable;
    external_irq_enable <= next_external_irq_enable;
    gate_sequence_flag  <= next_gate_sequence_flag;
    irq1_active         <= next_irq1_active;
    irq12_active        <= next_irq12_active;
    address_gate_state  <= next_address_gate_state;
    input_byte          <= next_input_byte;
    output_byte         <= next_output_byte;
    status              <= next_status;
    rdata               <= next_rdata;
    mismatch            <= next_mismatch;
  end

  assign reg_rdata_o     = rdata;
  // 60h reads return the emulated output byte; 64h reads the emulated status
  assign io_rdata_o      = (io_i.port == lke_pkg::PORT_CMD) ? status : output_byte;
  assign irq1_o  = legacy_irq_enable && status[lke_pkg::S_OUT_FULL] &&
                   !status[lke_pkg::S_AUX_FULL];
  assign irq12_o = legacy_irq_enable && status[lke_pkg::S_OUT_FULL] &&
                   status[lke_pkg::S_AUX_FULL];
  assign emu_irq_o       = emu_cond;
  assign gate_mismatch_o = mismatch;
endmodule : lke_core
`default_nettype wire

/* lke_pkg.sv */
// package for the legacy keyboard emulation block: offsets, fields, carriers
package lke_pkg;
  localparam int unsigned ADDR_W   = 12;
  localparam logic [11:0] OFF_CTRL = 12'h100;
  localparam logic [11:0] OFF_IN   = 12'h104;
  localparam logic [11:0] OFF_OUT  = 12'h108;
  localparam logic [11:0] OFF_STAT = 12'h10c;
  // host i/o ports that are trapped
  localparam logic [15:0] PORT_DATA = 16'h0060;
  localparam logic [15:0] PORT_CMD  = 16'h0064;
  localparam logic [7:0]  CMD_GATE  = 8'hd1;
  // control field positions
  localparam int unsigned C_EMU_ON   = 0;
  localparam int unsigned C_EMU_IRQ  = 1;
  localparam int unsigned C_CHAR_PND = 2;
  localparam int unsigned C_IRQ_EN   = 3;
  localparam int unsigned C_EXT_EN   = 4;
  localparam int unsigned C_GATE_SEQ = 5;
  localparam int unsigned C_IRQ1_ACT = 6;
  localparam int unsigned C_IRQ12_ACT = 7;
  localparam int unsigned C_GATE_ST  = 8;
  // status field positions
  localparam int unsigned S_OUT_FULL = 0;
  localparam int unsigned S_IN_FULL  = 1;
  localparam int unsigned S_FLAG     = 2;
  localparam int unsigned S_CMD_DATA = 3;
  localparam int unsigned S_INHIBIT  = 4;
  localparam int unsigned S_AUX_FULL = 5;
  localparam int unsigned S_TIMEOUT  = 6;
  localparam int unsigned S_PARITY   = 7;
  localparam logic [8:0]  CTRL_RST = 9'h000;
  localparam logic [7:0]  STAT_RST = 8'h00;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  // one host i/o access, trapped from the legacy decode
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] port;
    logic [7:0]  data;
  } lke_io_t;
endpackage : lke_pkg

/* lke_edge.sv */
// rising edge detector with a two-stage synchroniser per input bit
`timescale 1ns/1ps
`default_nettype none
module lke_edge #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_i,   // controller clock
  input  wire logic             nrst_i,  // synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_i, // raw level inputs
  output logic      [WIDTH-1:0] level_o, // synchronised level
  output logic      [WIDTH-1:0] rise_o   // one-cycle pulse on rising edge
);
  // refused while the design is built, not at run time
  if (WIDTH < 1) begin : g_width_check
    $error("lke_edge: WIDTH must be at least 1");
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta;
      logic sync;
      logic prev;
      logic next_meta;
      logic next_sync;
      logic next_prev;
      always_comb begin
        next_meta = async_i[g];
        next_sync = meta;
        next_prev = sync;
        if (!nrst_i) begin
          next_meta = 1'b0;
          next_sync = 1'b0;
          next_prev = 1'b0;
        end
      end
      always_ff @(posedge clk_i) begin
        meta <= next_meta;
        sync <= next_sync;
        prev <= next_prev;
      end
      assign level_o[g] = sync;
      assign rise_o[g]  = sync & ~prev;
    end
  endgenerate
endmodule : lke_edge
`default_nettype wire

/* lke_far_model.sv */
// keyboard controller irq pins and host i/o software model
`timescale 1ns/1ps
`default_nettype none
module lke_far_model (
  input  wire logic            clk_i,      // controller clock
  input  wire logic [7:0]      io_rdata_i, // byte the core returns for a port read
  output var lke_pkg::lke_io_t io_o,       // host i/o access
  output logic      [7:0]      rdata_o,    // read byte taken at the access edge
  output logic                 irq1_o,     // keyboard irq1 level
  output logic                 irq12_o     // mouse irq12 level
);
  initial begin
    io_o = '0;
    rdata_o = 8'h00;
    irq1_o = 1'b0;
    irq12_o = 1'b0;
  end
  // each access held for one cycle; a released bus shows inverted values so stale data cannot match
  task automatic io(input logic wr, input logic [15:0] port, input logic [7:0] data);
    @(posedge clk_i);
    io_o <= '{wr: wr, rd: !wr, port: port, data: data};
    @(posedge clk_i);
    rdata_o <= io_rdata_i;
    io_o <= '{wr: 1'b0, rd: 1'b0, port: ~port, data: ~data};
    #1;
  endtask : io
  // held high long enough to cross the two-flop synchroniser
  task automatic pulse(input logic mouse);
    @(posedge clk_i);
    if (mouse) irq12_o <= 1'b1;
    else irq1_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    irq1_o <= 1'b0;
    irq12_o <= 1'b0;
  endtask : pulse
endmodule : lke_far_model
`default_nettype wire

/* lke_core_sva.sv */
// port assertions for the legacy keyboard emulation core
`timescale 1ns/1ps
`default_nettype none
module lke_core_sva (
  input wire logic                       clk_i,       // controller clock
  input wire logic                       nrst_i,      // synchronous reset, active low
  input wire logic [lke_pkg::ADDR_W-1:0] reg_addr_i,  // register address
  input wire logic [31:0]                reg_wdata_i, // register write data
  input wire logic                       reg_wr_i,    // write strobe
  input wire logic                       reg_rd_i,    // read strobe
  input wire logic [31:0]                reg_rdata_o, // read data
  input wire lke_pkg::lke_io_t           io_i,        // host i/o access
  input wire logic                       io_trap_o,   // access claimed
  input wire logic                       kbc_irq1_i,  // controller irq1 pin
  input wire logic                       irq1_o,      // irq1 out
  input wire logic                       irq12_o,     // irq12 out
  input wire logic                       emu_irq_o    // emulation interrupt
);
  logic [4:0] sh;
  logic [4:0] next_sh;
  wire logic hit = (io_i.wr || io_i.rd) &&
                   (io_i.port == lke_pkg::PORT_DATA || io_i.port == lke_pkg::PORT_CMD);
  // shadow of the software-owned enables, updated at the same edge as the design
  always_comb begin
    next_sh = sh;
    if (reg_wr_i && reg_addr_i == lke_pkg::OFF_CTRL) next_sh = reg_wdata_i[4:0];
    if (!nrst_i) next_sh = 5'h00;
  end
  always_ff @(posedge clk_i) begin
    sh <= next_sh;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_trap_when_on: assert property (sh[0] && hit |-> io_trap_o) else $error("port not trapped");
  a_trap_only_on: assert property (io_trap_o |-> sh[0] && hit) else $error("stray trap");
  a_irq_one_line: assert property (!(irq1_o && irq12_o)) else $error("both irq lines high");
  a_irq_gated: assert property (irq1_o || irq12_o |-> sh[3]) else $error("irq without enable");
  a_emu_quiet: assert property (!sh[0] && !sh[2] && !sh[4] |-> !emu_irq_o)
    else $error("emulation irq with all enables off");
  a_bit1_live: assert property ($past(reg_rd_i) && $past(reg_addr_i) == lke_pkg::OFF_CTRL
    |-> reg_rdata_o[1] == $past(emu_irq_o)) else $error("control bit 1 not live");
  a_ctrl_resv: assert property ($past(reg_rd_i) && $past(reg_addr_i) == lke_pkg::OFF_CTRL
    |-> reg_rdata_o[31:9] == 23'h0) else $error("control reserved bits set");
  a_input_resv: assert property ($past(reg_rd_i) && $past(reg_addr_i) == lke_pkg::OFF_IN
    |-> reg_rdata_o[31:8] == 24'h0) else $error("input reserved bits set");
  a_ext_follow: assert property (sh[4] && $past(kbc_irq1_i, 2) && $past(nrst_i)
    && $past(nrst_i, 2) |-> emu_irq_o) else $error("external irq not forwarded");
  c_trap: cover property (io_trap_o);
  c_irq12: cover property (irq12_o);
  c_ext: cover property (sh[4] && emu_irq_o);
endmodule : lke_core_sva
bind lke_core lke_core_sva u_lke_core_sva (.clk_i(clk_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .io_i(io_i), .io_trap_o(io_trap_o),
  .kbc_irq1_i(kbc_irq1_i), .irq1_o(irq1_o), .irq12_o(irq12_o), .emu_irq_o(emu_irq_o));
`default_nettype wire

/* legacy_keyboard_emulation_bench.sv */
// self-checking bench for the legacy keyboard emulation core
`timescale 1ns/1ps
`default_nettype none
module legacy_keyboard_emulation_bench;
  typedef struct packed {
    logic [15:0] port;
    logic [7:0]  data;
    logic [7:0]  stat;
    logic        gate;
    logic        mis;
  } lke_row_t;
  logic             clk_i = 1'b0;
  logic             nrst_i = 1'b0;
  logic [11:0]      reg_addr = 12'h000;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [31:0]      reg_rdata;
  lke_pkg::lke_io_t io;
  logic             kirq1, kirq12, irq1, irq12, emu_irq, mis;
  logic [7:0]       io_rdata, host_rdata;
  logic [31:0]      v;
  int               n_mismatch = 0;
  int               comparisons = 0;
  // gate sequence order matters: rows 3 to 5 run inside one sequence
  lke_row_t rows [6] = '{'{16'h0060, 8'h55, 8'h02, 1'b0, 1'b0},
                        '{16'h0064, 8'haa, 8'h0a, 1'b0, 1'b0},
                        '{16'h0064, 8'hd1, 8'h08, 1'b1, 1'b0},
                        '{16'h0060, 8'h02, 8'h02, 1'b1, 1'b1},
                        '{16'h0060, 8'h00, 8'h00, 1'b1, 1'b0},
                        '{16'h0064, 8'hff, 8'h08, 1'b0, 1'b0}};
  always #5 clk_i = ~clk_i;
  lke_core u_lke_core (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .io_i(io), .io_rdata_o(io_rdata), .io_trap_o(), .kbc_irq1_i(kirq1), .kbc_irq12_i(kirq12),
    .irq1_o(irq1), .irq12_o(irq12), .emu_irq_o(emu_irq), .gate_mismatch_o(mis));
  lke_far_model u_lke_far_model (.clk_i(clk_i), .io_rdata_i(io_rdata), .io_o(io),
    .rdata_o(host_rdata), .irq1_o(kirq1), .irq12_o(kirq12));
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a, v);
    chk("register", exp, v);
  endtask : rchk
  task automatic final_report;
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int k = 0; k < 4; k++) rchk(lke_pkg::OFF_CTRL + 12'(4 * k), 32'h0);
    wr(lke_pkg::OFF_CTRL, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      wr(lke_pkg::OFF_STAT, 32'h0);
      u_lke_far_model.io(1'b1, rows[i].port, rows[i].data);
      chk("gate_mismatch_o", {31'h0, rows[i].mis}, {31'h0, mis});
      rchk(lke_pkg::OFF_IN, {24'h0, rows[i].data});
      rchk(lke_pkg::OFF_STAT, {24'h0, rows[i].stat});
      rchk(lke_pkg::OFF_CTRL, {26'h0, rows[i].gate, 3'h0, rows[i].stat[1], 1'b1});
    end
    // gate state high agrees with a set gate bit: no input full
    wr(lke_pkg::OFF_CTRL, 32'h0000_0101);
    wr(lke_pkg::OFF_STAT, 32'h0);
    u_lke_far_model.io(1'b1, lke_pkg::PORT_CMD, lke_pkg::CMD_GATE);
    u_lke_far_model.io(1'b1, lke_pkg::PORT_DATA, 8'h02);
    chk("gate_mismatch_o", 32'h0, {31'h0, mis});
    rchk(lke_pkg::OFF_STAT, 32'h0);
    rchk(lke_pkg::OFF_CTRL, 32'h0000_0121);
    wr(lke_pkg::OFF_CTRL, 32'h0000_0009);
    wr(lke_pkg::OFF_STAT, 32'h0000_0021);
    chk("irq12_o", 32'h1, {30'h0, irq1, irq12});
    wr(lke_pkg::OFF_STAT, 32'h0000_0001);
    chk("irq1_o", 32'h2, {30'h0, irq1, irq12});
    wr(lke_pkg::OFF_OUT, 32'h0000_005a);
    u_lke_far_model.io(1'b0, lke_pkg::PORT_CMD, 8'h00);
    chk("io_rdata_o", 32'h0000_0001, {24'h0, host_rdata});
    u_lke_far_model.io(1'b0, lke_pkg::PORT_DATA, 8'h00);
    chk("io_rdata_o", 32'h0000_005a, {24'h0, host_rdata});
    chk("irq1_o", 32'h0, {30'h0, irq1, irq12});
    wr(lke_pkg::OFF_CTRL, 32'h0000_0004);
    chk("emu_irq_o", 32'h1, {31'h0, emu_irq});
    wr(lke_pkg::OFF_STAT, 32'h0000_0001);
    chk("emu_irq_o", 32'h0, {31'h0, emu_irq});
    u_lke_far_model.io(1'b1, lke_pkg::PORT_DATA, 8'h77);
    rchk(lke_pkg::OFF_IN, 32'h0000_0002);
    // gate flag (bit 5) is still set from the sequence above
    wr(lke_pkg::OFF_CTRL, 32'h0000_0010);
    u_lke_far_model.pulse(1'b0);
    repeat (3) @(posedge clk_i);
    rchk(lke_pkg::OFF_CTRL, 32'h0000_0070);
    wr(lke_pkg::OFF_CTRL, 32'h0000_0050);
    rchk(lke_pkg::OFF_CTRL, 32'h0000_0030);
    u_lke_far_model.pulse(1'b1);
    repeat (3) @(posedge clk_i);
    rchk(lke_pkg::OFF_CTRL, 32'h0000_00b0);
    wr(lke_pkg::OFF_CTRL, 32'h0000_0010);
    rchk(lke_pkg::OFF_CTRL, 32'h0000_00b0);
    wr(lke_pkg::OFF_CTRL, 32'h0000_0090);
    rchk(lke_pkg::OFF_CTRL, 32'h0000_0030);
    wr(lke_pkg::OFF_CTRL, 32'hffff_fe00);
    rchk(lke_pkg::OFF_CTRL, 32'h0000_0020);
    wr(lke_pkg::OFF_IN, 32'hffff_ffff);
    rchk(lke_pkg::OFF_IN, 32'h0000_00ff);
    wr(12'h200, 32'hffff_ffff);
    rchk(12'h200, 32'h0);
    // a reset in mid-run must drop the input byte, status and control flags picked up above
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    rchk(lke_pkg::OFF_IN, 32'h0);
    rchk(lke_pkg::OFF_STAT, 32'h0);
    rchk(lke_pkg::OFF_CTRL, 32'h0);
    final_report();
  end
endmodule : legacy_keyboard_emulation_bench
`default_nettype wire
